/* rtl/mbl_defines.svh */
`ifndef MBL_DEFINES_SVH
`define MBL_DEFINES_SVH

// ==========================================================
// clock and sequence time base
`define MBL_CLK_NS 100
`define MBL_TICK_US 125
`define MBL_TICK_CYCLES (`MBL_TICK_US * 1000 / `MBL_CLK_NS)
`define MBL_MS2TICK(ms) (16'((ms) * 1000 / `MBL_TICK_US))
`define MBL_STEPS_PER_CYCLE 6
`define MBL_FC_STEP_TICKS(us) \
	(16'((us) / `MBL_TICK_US / `MBL_STEPS_PER_CYCLE))

// ==========================================================
// register offsets and slot indices
`define MBL_OFS_FILTER 8'h0f
`define MBL_OFS_START 8'h10
`define MBL_OFS_SENSE 8'h12
`define MBL_OFS_BRAKE 8'h13
`define MBL_OFS_EXCITE 8'h14
`define MBL_OFS_FORCED 8'h15
`define MBL_OFS_LEVEL 8'h17
`define MBL_OFS_COMP 8'h18
`define MBL_IDX_FILTER 3'h0
`define MBL_IDX_START 3'h1
`define MBL_IDX_SENSE 3'h2
`define MBL_IDX_BRAKE 3'h3
`define MBL_IDX_EXCITE 3'h4
`define MBL_IDX_FORCED 3'h5
`define MBL_IDX_LEVEL 3'h6
`define MBL_IDX_COMP 3'h7
`define MBL_CFG_RST 8'h00

// ==========================================================
// field positions
`define MBL_F_FILT_LEN 1:0
`define MBL_F_START_SCALE 3:1
`define MBL_F_LIMIT_DIS 0
`define MBL_F_SENSE_SEL 2:1
`define MBL_F_BRAKE_SHORT 4
`define MBL_F_BRAKE_HOLD 3
`define MBL_F_BRAKE_SECS 2:0
`define MBL_F_EXC1 4:3
`define MBL_F_EXC2 2:0
`define MBL_F_FC_FREQ 1:0
`define MBL_F_LEVEL 6
`define MBL_F_HYST 7:6

// ==========================================================
// sequence periods, as printed
`define MBL_BRAKE_UNIT_MS 1000
`define MBL_EXC1_MS0 0
`define MBL_EXC1_MS1 200
`define MBL_EXC1_MS2 500
`define MBL_EXC1_MS3 1000
`define MBL_EXC2_MS0 100
`define MBL_EXC2_MS1 200
`define MBL_EXC2_MS2 400
`define MBL_EXC2_MS3 600
`define MBL_EXC2_MS4 800
`define MBL_EXC2_MS5 1000
`define MBL_EXC2_MS6 1500
`define MBL_EXC2_MS7 2000
`define MBL_FC_PERIOD_US0 625000
`define MBL_FC_PERIOD_US1 312500
`define MBL_FC_PERIOD_US2 156250
`define MBL_FC_PERIOD_US3 78125
`define MBL_WIN_MS0 200
`define MBL_WIN_MS1 100
`define MBL_WIN_MS2 50
`define MBL_WIN_MS3 25

// ==========================================================
// digital filter lengths in clocks
`define MBL_OCP_LEN0 4'h0
`define MBL_OCP_LEN1 4'h4
`define MBL_OCP_LEN2 4'h6
`define MBL_OCP_LEN3 4'h7
`define MBL_ISD_LEN0 4'h1
`define MBL_ISD_LEN1 4'h5
`define MBL_ISD_LEN2 4'h7
`define MBL_ISD_LEN3 4'h8

// ==========================================================
// commutation steps
`define MBL_IDLE_MIN_EDGES 3'h6
`define MBL_EXC_STEP 3'h0
`define MBL_STEP_BAD 3'h7
`define MBL_STEP_LAST 3'h5

`endif

/* rtl/mbl_pkg.sv */
package mbl_pkg;

	// ==========================================================
	// sequencer states, one-hot
	typedef enum logic [9:0] {
		ST_LOAD = 10'h001,
		ST_BRAKE = 10'h002,
		ST_HOLD = 10'h004,
		ST_IDLE = 10'h008,
		ST_DETECT = 10'h010,
		ST_EXC1 = 10'h020,
		ST_EXC2 = 10'h040,
		ST_FORCED = 10'h080,
		ST_SENSE = 10'h100,
		ST_ERROR = 10'h200
	} mbl_state_t;

	typedef logic [15:0] mbl_ticks_t;
	typedef logic [2:0] mbl_step_t;

endpackage

/* rtl/mbl_comp_filter.sv */
`timescale 1ns/100ps

module mbl_comp_filter #(
	parameter int CNT_W = 4
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic rawIn,
	input wire logic [CNT_W-1:0] filterLen,
	output logic filtOut
);
	logic sync1_q;
	logic sync2_q;
	logic [CNT_W-1:0] run_q;

	// ==========================================================
	// two-stage synchroniser; first stage feeds only the second
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
		end else begin
			sync1_q <= rawIn;
			sync2_q <= sync1_q;
		end
	end

	// ==========================================================
	// count prior high cycles, saturating so long pulses stay high
	always_ff @(posedge ref_clk) begin
		if (!rst_n || !sync2_q) begin
			run_q <= '0;
		end else if (run_q != {CNT_W{1'b1}}) begin
			run_q <= run_q + 1'b1;
		end
	end

	// length zero passes the synchronised level straight on
	assign filtOut = sync2_q && (run_q >= filterLen);

endmodule // mbl_comp_filter

/* rtl/mbl_phase_timer.sv */
`timescale 1ns/100ps

module mbl_phase_timer #(
	parameter int TICK_CYCLES = 1250
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic start,
	input wire mbl_pkg::mbl_ticks_t duration,
	output logic done
);
	import mbl_pkg::*;

	localparam int DIV_W = $clog2(TICK_CYCLES + 1);

	logic [DIV_W-1:0] div_q;
	mbl_ticks_t count_q;
	mbl_ticks_t dur_q;
	logic tick;

	assign tick = (div_q == DIV_W'(TICK_CYCLES - 1));

	// ==========================================================
	// tick divider, realigned on start so every phase is exact
	always_ff @(posedge ref_clk) begin
		if (!rst_n || start || tick) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// ==========================================================
	// phase length counter, restarted on each phase entry
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_q <= '0;
			dur_q <= '0;
		end else if (start) begin
			count_q <= '0;
			dur_q <= duration;
		end else if (tick && !done) begin
			count_q <= count_q + 1'b1;
		end
	end

	// held state only, never start, so the sequencer's next-state
	// logic cannot close a loop through it; zero duration is done
	// on the first cycle of its phase
	assign done = (count_q >= dur_q);

endmodule // mbl_phase_timer

/* rtl/mbl_sequencer.sv */
`timescale 1ns/100ps
`include "mbl_defines.svh"

module mbl_sequencer #(
	parameter int TICK_CYCLES = `MBL_TICK_CYCLES,
	parameter int FC_STEPS = 6
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic configLoaded,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	output logic [7:0] regRdData,
	input wire logic speedCmdActive,
	input wire logic faultStop,
	input wire logic pwmPeriodStart,
	input wire logic pwmOn,
	input wire logic limitCompare,
	input wire logic overcurrentCompare,
	input wire logic [2:0] positionCompare,
	output logic [2:0] highGate,
	output logic [2:0] lowGate,
	output logic [2:0] limitThresholdScale,
	output logic limitThresholdLevel,
	output logic [1:0] positionHysteresis,
	output logic [1:0] senseFilterSelect,
	output logic overcurrentDetected,
	output mbl_pkg::mbl_state_t motorState
);
	import mbl_pkg::*;

	logic [7:0] cfg_q [0:7];
	mbl_state_t state_q;
	mbl_state_t state_d;
	mbl_step_t step_q;
	mbl_step_t prevStep_q;
	mbl_step_t posStep;
	logic [2:0] fwdEdges_q;
	logic [3:0] fcCount_q;
	logic cut_q;
	logic phaseStart;
	logic phaseDone;
	mbl_ticks_t phaseDur;
	logic [3:0] ocpLen;
	logic [3:0] isdLen;
	logic ocpFilt;
	logic [2:0] posSync;
	logic driving;
	logic [5:0] gateSet;
	logic [2:0] highGate_q;
	logic [2:0] lowGate_q;
	logic [7:0] rdData_q;
	logic [2:0] scale_q;
	logic [3:0] regSel;

	// ==========================================================
	// register decode: hit flag and slot index
	function automatic logic [3:0] regSlot(input logic [7:0] a);
		if (a == `MBL_OFS_FILTER) return {1'b1, `MBL_IDX_FILTER};
		else if (a == `MBL_OFS_START) return {1'b1, `MBL_IDX_START};
		else if (a == `MBL_OFS_SENSE) return {1'b1, `MBL_IDX_SENSE};
		else if (a == `MBL_OFS_BRAKE) return {1'b1, `MBL_IDX_BRAKE};
		else if (a == `MBL_OFS_EXCITE) return {1'b1, `MBL_IDX_EXCITE};
		else if (a == `MBL_OFS_FORCED) return {1'b1, `MBL_IDX_FORCED};
		else if (a == `MBL_OFS_LEVEL) return {1'b1, `MBL_IDX_LEVEL};
		else if (a == `MBL_OFS_COMP) return {1'b1, `MBL_IDX_COMP};
		else return 4'h0;
	endfunction

	// comparator pattern to commutation step, bad code for 000/111
	function automatic mbl_step_t posToStep(input logic [2:0] p);
		case (p)
			3'h5: return 3'h0;
			3'h4: return 3'h1;
			3'h6: return 3'h2;
			3'h2: return 3'h3;
			3'h3: return 3'h4;
			3'h1: return 3'h5;
			default: return `MBL_STEP_BAD;
		endcase
	endfunction

	// six-step gate pattern {high U V W, low U V W}
	function automatic logic [5:0] gatesFor(input mbl_step_t s);
		case (s)
			3'h0: return 6'h22;
			3'h1: return 6'h21;
			3'h2: return 6'h11;
			3'h3: return 6'h14;
			3'h4: return 6'h0c;
			3'h5: return 6'h0a;
			default: return 6'h00;
		endcase
	endfunction

	function automatic mbl_step_t nextStep(input mbl_step_t s);
		return (s == `MBL_STEP_LAST) ? 3'h0 : 3'(s + 3'h1);
	endfunction

	// one decode shared by write and read; a call result cannot be sliced
	assign regSel = regSlot(regAddr);

	// ==========================================================
	// configuration registers
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 8; i++) begin
				cfg_q[i] <= `MBL_CFG_RST;
			end
		end else if (regWrEn && regSel[3]) begin
			cfg_q[regSel[2:0]] <= regWrData;
		end
	end

	// registered read; unmapped offsets read zero
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rdData_q <= 8'h00;
		end else if (regSel[3]) begin
			rdData_q <= cfg_q[regSel[2:0]];
		end else begin
			rdData_q <= 8'h00;
		end
	end
	assign regRdData = rdData_q;

	// ==========================================================
	// comparator inputs: synchronise then filter
	always_comb begin
		case (cfg_q[`MBL_IDX_FILTER][`MBL_F_FILT_LEN])
			2'h0: begin ocpLen = `MBL_OCP_LEN0; isdLen = `MBL_ISD_LEN0; end
			2'h1: begin ocpLen = `MBL_OCP_LEN1; isdLen = `MBL_ISD_LEN1; end
			2'h2: begin ocpLen = `MBL_OCP_LEN2; isdLen = `MBL_ISD_LEN2; end
			default: begin ocpLen = `MBL_OCP_LEN3; isdLen = `MBL_ISD_LEN3; end
		endcase
	end

	mbl_comp_filter #(.CNT_W(4)) u_ocp_filter (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.rawIn(limitCompare),
		.filterLen(ocpLen),
		.filtOut(ocpFilt)
	);

	mbl_comp_filter #(.CNT_W(4)) u_isd_filter (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.rawIn(overcurrentCompare),
		.filterLen(isdLen),
		.filtOut(overcurrentDetected)
	);

	// position comparators need only the synchroniser
	for (genvar g = 0; g < 3; g++) begin : g_pos
		mbl_comp_filter #(.CNT_W(1)) u_pos_sync (
			.ref_clk(ref_clk),
			.rst_n(rst_n),
			.rawIn(positionCompare[g]),
			.filterLen(1'b0),
			.filtOut(posSync[g])
		);
	end
	assign posStep = posToStep(posSync);

	// ==========================================================
	// phase timing, restarted on entry and on every forced step
	assign phaseStart = (state_d != state_q) ||
		(state_q == ST_FORCED && phaseDone);

	always_comb begin
		phaseDur = '0;
		case (state_d)
			ST_BRAKE: phaseDur = 16'(cfg_q[`MBL_IDX_BRAKE][`MBL_F_BRAKE_SECS]
				* `MBL_MS2TICK(`MBL_BRAKE_UNIT_MS));
			ST_DETECT: begin
				case (cfg_q[`MBL_IDX_FORCED][`MBL_F_FC_FREQ])
					2'h0: phaseDur = `MBL_MS2TICK(`MBL_WIN_MS0);
					2'h1: phaseDur = `MBL_MS2TICK(`MBL_WIN_MS1);
					2'h2: phaseDur = `MBL_MS2TICK(`MBL_WIN_MS2);
					default: phaseDur = `MBL_MS2TICK(`MBL_WIN_MS3);
				endcase
			end
			ST_EXC1: begin
				case (cfg_q[`MBL_IDX_EXCITE][`MBL_F_EXC1])
					2'h0: phaseDur = `MBL_MS2TICK(`MBL_EXC1_MS0);
					2'h1: phaseDur = `MBL_MS2TICK(`MBL_EXC1_MS1);
					2'h2: phaseDur = `MBL_MS2TICK(`MBL_EXC1_MS2);
					default: phaseDur = `MBL_MS2TICK(`MBL_EXC1_MS3);
				endcase
			end
			ST_EXC2: begin
				case (cfg_q[`MBL_IDX_EXCITE][`MBL_F_EXC2])
					3'h0: phaseDur = `MBL_MS2TICK(`MBL_EXC2_MS0);
					3'h1: phaseDur = `MBL_MS2TICK(`MBL_EXC2_MS1);
					3'h2: phaseDur = `MBL_MS2TICK(`MBL_EXC2_MS2);
					3'h3: phaseDur = `MBL_MS2TICK(`MBL_EXC2_MS3);
					3'h4: phaseDur = `MBL_MS2TICK(`MBL_EXC2_MS4);
					3'h5: phaseDur = `MBL_MS2TICK(`MBL_EXC2_MS5);
					3'h6: phaseDur = `MBL_MS2TICK(`MBL_EXC2_MS6);
					default: phaseDur = `MBL_MS2TICK(`MBL_EXC2_MS7);
				endcase
			end
			ST_FORCED: begin
				case (cfg_q[`MBL_IDX_FORCED][`MBL_F_FC_FREQ])
					2'h0: phaseDur = `MBL_FC_STEP_TICKS(`MBL_FC_PERIOD_US0);
					2'h1: phaseDur = `MBL_FC_STEP_TICKS(`MBL_FC_PERIOD_US1);
					2'h2: phaseDur = `MBL_FC_STEP_TICKS(`MBL_FC_PERIOD_US2);
					default: phaseDur = `MBL_FC_STEP_TICKS(`MBL_FC_PERIOD_US3);
				endcase
			end
			default: phaseDur = '0;
		endcase
	end

	mbl_phase_timer #(.TICK_CYCLES(TICK_CYCLES)) u_phase_timer (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.start(phaseStart),
		.duration(phaseDur),
		.done(phaseDone)
	);

	// ==========================================================
	// next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_LOAD: if (configLoaded) state_d = ST_BRAKE;
			ST_BRAKE: begin
				// hold is meaningless for a zero-length brake
				if (phaseDone) begin
					if (cfg_q[`MBL_IDX_BRAKE][`MBL_F_BRAKE_HOLD] &&
						cfg_q[`MBL_IDX_BRAKE][`MBL_F_BRAKE_SECS] != 3'h0) begin
						state_d = ST_HOLD;
					end else begin
						state_d = ST_IDLE;
					end
				end
			end
			ST_HOLD: if (speedCmdActive) state_d = ST_DETECT;
			ST_IDLE: if (speedCmdActive) state_d = ST_DETECT;
			ST_DETECT: begin
				if (fwdEdges_q >= `MBL_IDLE_MIN_EDGES) begin
					state_d = ST_SENSE;
				end else if (phaseDone) begin
					state_d = ST_EXC1;
				end
			end
			ST_EXC1: if (phaseDone) state_d = ST_EXC2;
			ST_EXC2: if (phaseDone) state_d = ST_FORCED;
			ST_FORCED: begin
				if (phaseDone && fcCount_q == 4'(FC_STEPS - 1)) begin
					state_d = ST_SENSE;
				end
			end
			ST_ERROR: if (!speedCmdActive) state_d = ST_IDLE;
			default: state_d = state_q;
		endcase
		// running states: stop wins over fault, both over progress
		if (driving || state_q == ST_DETECT) begin
			if (!speedCmdActive) begin
				state_d = ST_IDLE;
			end else if (faultStop) begin
				state_d = ST_ERROR;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_q <= ST_LOAD;
		end else begin
			state_q <= state_d;
		end
	end
	assign motorState = state_q;

	assign driving = (state_q == ST_EXC1) || (state_q == ST_EXC2) ||
		(state_q == ST_FORCED) || (state_q == ST_SENSE);

	// ==========================================================
	// idling detection: count forward steps seen while gates are off
	always_ff @(posedge ref_clk) begin
		if (!rst_n || state_q != ST_DETECT) begin
			fwdEdges_q <= 3'h0;
			prevStep_q <= `MBL_STEP_BAD;
		end else if (posStep != `MBL_STEP_BAD && posStep != prevStep_q) begin
			prevStep_q <= posStep;
			// a reverse or jumbled step restarts the count
			if (prevStep_q != `MBL_STEP_BAD &&
				posStep == nextStep(prevStep_q)) begin
				if (fwdEdges_q != 3'h7) fwdEdges_q <= fwdEdges_q + 3'h1;
			end else begin
				fwdEdges_q <= 3'h0;
			end
		end
	end

	// ==========================================================
	// commutation step
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			step_q <= `MBL_EXC_STEP;
			fcCount_q <= 4'h0;
		end else if (state_q == ST_EXC1 || state_q == ST_EXC2) begin
			step_q <= `MBL_EXC_STEP;
			fcCount_q <= 4'h0;
		end else if (state_q == ST_FORCED && phaseDone) begin
			step_q <= nextStep(step_q);
			fcCount_q <= fcCount_q + 4'h1;
		end else if (state_q == ST_SENSE && posStep != `MBL_STEP_BAD) begin
			step_q <= nextStep(posStep);
		end else if (state_q == ST_DETECT && posStep != `MBL_STEP_BAD) begin
			step_q <= nextStep(posStep); // direct entry follows rotor
		end
	end

	// ==========================================================
	// cycle-by-cycle limit; a trip in the clearing cycle still holds
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			cut_q <= 1'b0;
		end else if (ocpFilt && driving &&
			!cfg_q[`MBL_IDX_START][`MBL_F_LIMIT_DIS]) begin
			cut_q <= 1'b1;
		end else if (pwmPeriodStart) begin
			cut_q <= 1'b0;
		end
	end

	// ==========================================================
	// gate drive; registered so gates never glitch on decode
	assign gateSet = gatesFor(step_q);

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			highGate_q <= 3'h0;
			lowGate_q <= 3'h0;
		end else if (state_q == ST_BRAKE || state_q == ST_HOLD) begin
			highGate_q <= 3'h0;
			lowGate_q <= {3{cfg_q[`MBL_IDX_BRAKE][`MBL_F_BRAKE_SHORT]}};
		end else if (driving) begin
			highGate_q <= gateSet[5:3] & {3{pwmOn && !cut_q}};
			lowGate_q <= gateSet[2:0];
		end else begin
			highGate_q <= 3'h0;
			lowGate_q <= 3'h0;
		end
	end
	assign highGate = highGate_q;
	assign lowGate = lowGate_q;

	// ==========================================================
	// analog threshold and comparator selections
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			scale_q <= 3'h0;
		end else if (state_q == ST_SENSE) begin
			scale_q <= 3'h0;
		end else begin
			scale_q <= cfg_q[`MBL_IDX_START][`MBL_F_START_SCALE];
		end
	end
	assign limitThresholdScale = scale_q;
	assign limitThresholdLevel = cfg_q[`MBL_IDX_LEVEL][`MBL_F_LEVEL];
	assign positionHysteresis = cfg_q[`MBL_IDX_COMP][`MBL_F_HYST];
	assign senseFilterSelect = cfg_q[`MBL_IDX_SENSE][`MBL_F_SENSE_SEL];

endmodule // mbl_sequencer

/* verif/mbl_sequencer_sva.sv */
`timescale 1ns/100ps

// ==========================================================
// sequencing checks seen from the top ports
module mbl_sequencer_chk
	import mbl_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic configLoaded,
	input wire logic speedCmdActive,
	input wire logic [2:0] highGate,
	input wire logic [2:0] lowGate,
	input wire logic [2:0] limitThresholdScale,
	input wire mbl_pkg::mbl_state_t motorState
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// states that a speed stop must end
	logic running;
	assign running = motorState inside {ST_DETECT, ST_EXC1, ST_EXC2,
		ST_FORCED, ST_SENSE, ST_ERROR};

	// ==========================================================
	// gate and threshold states, one cycle behind the state register
	idle_gates_off_a: assert property ($past(motorState) == ST_IDLE &&
		motorState == ST_IDLE |-> highGate == 3'h0 && lowGate == 3'h0)
		else $error("gates on while idle");
	brake_high_off_a: assert property ($past(motorState) inside
		{ST_BRAKE, ST_HOLD} && motorState inside {ST_BRAKE, ST_HOLD}
		|-> highGate == 3'h0) else $error("high side on in brake");
	sense_scale_a: assert property ($past(motorState) == ST_SENSE &&
		motorState == ST_SENSE |-> limitThresholdScale == 3'h0)
		else $error("startup threshold kept in sensorless step");

	// ==========================================================
	// order of the sequence
	load_brake_a: assert property (motorState == ST_LOAD &&
		configLoaded |=> motorState == ST_BRAKE)
		else $error("no brake after load");
	brake_exit_a: assert property ($past(motorState) == ST_BRAKE &&
		motorState != ST_BRAKE |-> motorState inside {ST_HOLD, ST_IDLE})
		else $error("bad brake exit");
	hold_start_a: assert property (motorState == ST_HOLD &&
		speedCmdActive |=> motorState == ST_DETECT)
		else $error("hold did not start");
	stop_idle_a: assert property (running && !speedCmdActive
		|=> motorState == ST_IDLE) else $error("speed stop ignored");
	idle_start_a: assert property (motorState == ST_IDLE &&
		speedCmdActive |=> motorState == ST_DETECT)
		else $error("idle did not start");
	exc_order_a: assert property (motorState == ST_EXC2 &&
		$past(motorState) != ST_EXC2 |-> $past(motorState) == ST_EXC1)
		else $error("second excitation out of order");
	forced_order_a: assert property (motorState == ST_FORCED &&
		$past(motorState) != ST_FORCED |-> $past(motorState) == ST_EXC2)
		else $error("forced steps out of order");
	detect_exit_a: assert property ($past(motorState) == ST_DETECT &&
		motorState != ST_DETECT |-> motorState inside {ST_SENSE, ST_EXC1,
		ST_IDLE, ST_ERROR}) else $error("bad exit from idling check");
endmodule // mbl_sequencer_chk

bind mbl_sequencer mbl_sequencer_chk chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.configLoaded(configLoaded), .speedCmdActive(speedCmdActive),
	.highGate(highGate), .lowGate(lowGate),
	.limitThresholdScale(limitThresholdScale), .motorState(motorState));

/* verif/mbl_bridge_model.sv */
`timescale 1ns/100ps

// ==========================================================
// inverter bridge and motor seen by the comparators
module mbl_bridge_model (
	input wire logic ref_clk,
	input wire logic [2:0] highGate,
	input wire logic spinFwd,
	input wire logic overload,
	output logic [2:0] positionCompare,
	output logic limitCompare
);
	logic [2:0] fwdSeq [6] = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
	logic [5:0] stepDiv_q = 6'h00;
	logic [2:0] stepIdx_q = 3'h0;

	// rotor steps every 50 clocks; a stopped rotor holds its position
	always_ff @(posedge ref_clk) begin
		if (spinFwd) begin
			stepDiv_q <= (stepDiv_q == 6'h31) ? 6'h00 : stepDiv_q + 6'h01;
			if (stepDiv_q == 6'h31) begin
				stepIdx_q <= (stepIdx_q == 3'h5) ? 3'h0 : stepIdx_q + 3'h1;
			end
		end
	end
	assign positionCompare = fwdSeq[stepIdx_q];
	// shunt sees current only while a high side conducts
	assign limitCompare = overload && (|highGate);
endmodule // mbl_bridge_model

/* verif/test_motor_brake_startup_current_limit.sv */
`timescale 1ns/100ps

module test_motor_brake_startup_current_limit;
	import mbl_pkg::*;
	logic ref_clk, rst_n, configLoaded, regWrEn, speedCmdActive, faultStop;
	logic pwmPeriodStart, pwmOn, overcurrentCompare, spinFwd, overload;
	logic limitCompare, limitThresholdLevel, overcurrentDetected;
	logic [7:0] regAddr, regWrData, regRdData;
	logic [2:0] positionCompare, highGate, lowGate, limitThresholdScale;
	logic [1:0] positionHysteresis, senseFilterSelect;
	mbl_state_t motorState;
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	// address, write data, expected read back
	logic [23:0] rows [10] = '{24'h0f_0303, 24'h10_0e0e, 24'h12_0606,
		24'h13_1d1d, 24'h14_1f1f, 24'h15_0303, 24'h17_4040, 24'h18_c0c0,
		24'h11_ff00, 24'h16_ff00};

	// ==========================================================
	// clock, partner and design
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	mbl_bridge_model bridge (.ref_clk(ref_clk), .highGate(highGate),
		.spinFwd(spinFwd), .overload(overload),
		.positionCompare(positionCompare), .limitCompare(limitCompare));
	mbl_sequencer #(.TICK_CYCLES(4)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.configLoaded(configLoaded), .regAddr(regAddr),
		.regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData),
		.speedCmdActive(speedCmdActive), .faultStop(faultStop),
		.pwmPeriodStart(pwmPeriodStart), .pwmOn(pwmOn),
		.limitCompare(limitCompare), .overcurrentCompare(overcurrentCompare),
		.positionCompare(positionCompare), .highGate(highGate),
		.lowGate(lowGate), .limitThresholdScale(limitThresholdScale),
		.limitThresholdLevel(limitThresholdLevel),
		.positionHysteresis(positionHysteresis),
		.senseFilterSelect(senseFilterSelect),
		.overcurrentDetected(overcurrentDetected), .motorState(motorState));

	// ==========================================================
	// shared tasks; inputs move 10 ns after the rising edge
	task tick(input int n);
		repeat (n) @(posedge ref_clk);
		#10;
	endtask
	task chk(input logic [9:0] got, input logic [9:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		regAddr = a;
		regWrData = d;
		regWrEn = 1'b1;
		tick(1);
		regWrEn = 1'b0;
		// an edge passes so a following write never retoggles the strobe
		tick(1);
	endtask
	task rdChk(input logic [7:0] a, input logic [7:0] exp);
		regAddr = a;
		tick(2);
		chk(10'(regRdData), 10'(exp));
	endtask
	// bounded wait, then the state itself is the comparison
	task waitSt(input mbl_state_t s, input int lim);
		for (int i = 0; i < lim && motorState !== s; i++) tick(1);
		chk(motorState, s);
	endtask
	task end_sim;
		if (err_total == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// cut a hang short; the full run needs about 40000 cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 60000) begin
			err_total++;
			end_sim();
		end
	end

	// ==========================================================
	// main sequence
	initial begin
		{rst_n, configLoaded, regWrEn, speedCmdActive, faultStop} = 5'h00;
		{pwmPeriodStart, pwmOn, overcurrentCompare, spinFwd, overload} = 5'h00;
		regAddr = 8'h00;
		regWrData = 8'h00;
		tick(2);
		rst_n = 1'b1;
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rdChk(rows[i][23:16], rows[i][7:0]);
		end
		chk(10'(positionHysteresis), 10'h003);
		chk(10'(limitThresholdLevel), 10'h001);
		chk(10'(senseFilterSelect), 10'h003);
		// longest detect filter: a level held 4 cycles must not pass yet, one held 14 cycles must
		overcurrentCompare = 1'b1;
		tick(4);
		chk(10'(overcurrentDetected), 10'h000);
		tick(10);
		chk(10'(overcurrentDetected), 10'h001);
		overcurrentCompare = 1'b0;
		// reset in mid-run clears everything
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		rdChk(8'h13, 8'h00);
		rdChk(8'h0f, 8'h00);
		chk(motorState, ST_LOAD);
		overcurrentCompare = 1'b1;
		tick(5);
		chk(10'(overcurrentDetected), 10'h001);
		overcurrentCompare = 1'b0;
		// one second of held short brake, then startup from standstill
		wr(8'h13, 8'h19);
		wr(8'h15, 8'h03);
		wr(8'h10, 8'h0a);
		configLoaded = 1'b1;
		tick(3);
		chk(motorState, ST_BRAKE);
		chk(10'({highGate, lowGate}), 10'h007);
		tick(30000);
		chk(motorState, ST_BRAKE);
		waitSt(ST_HOLD, 3000);
		tick(100);
		chk(10'({highGate, lowGate}), 10'h007);
		speedCmdActive = 1'b1;
		pwmOn = 1'b1;
		waitSt(ST_DETECT, 3);
		waitSt(ST_EXC2, 1000);
		tick(2);
		chk(10'({highGate, lowGate}), 10'h022);
		chk(10'(limitThresholdScale), 10'h005);
		// cutoff holds until the next period starts
		overload = 1'b1;
		tick(8);
		chk(10'(highGate), 10'h000);
		tick(20);
		overload = 1'b0;
		chk(10'(highGate), 10'h000);
		pwmPeriodStart = 1'b1;
		tick(1);
		pwmPeriodStart = 1'b0;
		tick(4);
		chk(10'(highGate), 10'h004);
		waitSt(ST_FORCED, 3300);
		waitSt(ST_SENSE, 3000);
		tick(2);
		chk(10'(limitThresholdScale), 10'h000);
		speedCmdActive = 1'b0;
		waitSt(ST_IDLE, 2);
		tick(2);
		chk(10'({highGate, lowGate}), 10'h000);
		// rotor already turning forward skips excitation
		spinFwd = 1'b1;
		tick(400);
		speedCmdActive = 1'b1;
		waitSt(ST_DETECT, 2);
		waitSt(ST_SENSE, 1200);
		wr(8'h10, 8'h01);
		overload = 1'b1;
		tick(12);
		chk(10'(|highGate), 10'h001);
		wr(8'h10, 8'h00);
		tick(8);
		chk(10'(highGate), 10'h000);
		overload = 1'b0;
		faultStop = 1'b1;
		waitSt(ST_ERROR, 3);
		faultStop = 1'b0;
		speedCmdActive = 1'b0;
		waitSt(ST_IDLE, 3);
		spinFwd = 1'b0;
		// hold option has no effect at zero brake time
		rst_n = 1'b0;
		configLoaded = 1'b0;
		tick(2);
		rst_n = 1'b1;
		wr(8'h13, 8'h08);
		configLoaded = 1'b1;
		waitSt(ST_IDLE, 10);
		end_sim();
	end
endmodule // test_motor_brake_startup_current_limit
